// [design/dspq_pkg.sv]
// Shared constants and carrier types for the scan pacer and queue block.
// Assumes a single 100 MHz clock and a plain strobe register port.
package dspq_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int EXT_MAX_KHZ = 50;                 // External pacing ceiling
  localparam int CTR_MAX_MHZ = 1;                  // Event counter ceiling
  // Shortest legal external pacing period in cycles, rounded down
  localparam int EXT_MIN_CYC = (CLK_MHZ * 1000) / EXT_MAX_KHZ;
  localparam int CTR_MIN_CYC = CLK_MHZ / CTR_MAX_MHZ;
  localparam logic [31:0] PACER_DIV_RST = 32'h000007CF; // Internal pacer divider reset

  // ==========================================================
  // Register map (byte addresses)
  localparam int AW = 8;
  localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [AW-1:0] ADDR_STATUS = 8'h04;
  localparam logic [AW-1:0] ADDR_QLEN = 8'h08;
  localparam logic [AW-1:0] ADDR_TOTAL = 8'h0C;
  localparam logic [AW-1:0] ADDR_PACER = 8'h10;
  localparam logic [AW-1:0] ADDR_EVCNT = 8'h14;
  localparam logic [AW-1:0] ADDR_RESULT = 8'h18;
  localparam logic [AW-1:0] ADDR_COUNT = 8'h1C;
  localparam logic [AW-1:0] ADDR_QBASE = 8'h40;    // 16 queue words at 0x40..0x7C
  localparam logic [AW-1:0] ADDR_QMASK = 8'h80;    // First address past the queue window

  // ==========================================================
  // Control register fields
  localparam int CTRL_START = 0;                   // Write 1 starts a scan (self clearing)
  localparam int CTRL_STOP = 1;                    // Write 1 ends a scan
  localparam int CTRL_EXTPACE = 2;                 // External pacing option
  localparam int CTRL_GATED = 3;                   // 1 = gated, 0 = continuous
  localparam int CTRL_SYNC_IN = 4;                 // 1 = sync pin is an input
  localparam int CTRL_TRIG_FALL = 5;               // 1 = falling trigger edge
  localparam int CTRL_TRIG_EN = 6;                 // Wait for trigger before pacing
  localparam int CTRL_SE = 7;                      // Single-ended input mode
  localparam int CTRL_CNT_CLR = 8;                 // Write 1 clears event counter

  // ==========================================================
  // Queue
  localparam int QDEPTH = 16;
  localparam int QIW = 4;
  localparam int CHW = 3;
  localparam int RGW = 3;
  localparam logic [RGW-1:0] range_bipolar_ten_volt = 3'h1;
  localparam logic [RGW-1:0] range_bipolar_five_volt = 3'h2;

  // ==========================================================
  // Conversion codes
  localparam int CW = 12;
  localparam logic [CW-1:0] CODE_MID = 12'h800;    // Zero volts
  localparam logic [CW-1:0] CODE_FULL = 12'hFFF;
  localparam logic [CW-1:0] CODE_SE_FULL = 12'h7FF;

  typedef struct packed {
    logic [CHW-1:0] chan;
    logic [RGW-1:0] range;
  } dspq_entry_type;

  typedef enum {ST_IDLE, ST_ARM, ST_RUN} dspq_state_type;

endpackage

// [design/dspq_top.sv]
// Scan sequencer: channel gain queue, pacer, sync pin, trigger, event counter.
// Assumes one 100 MHz clock, asynchronous active-low reset, and a converter
// front end that returns a signed reading plus an over-range flag per request.
//
// The register addresses and the plain strobed port were decided locally.

// Contract
// R01: Trigger edge polarity is host selectable
// R02: Sync pin is bidirectional clock in/out
// R03: External pacing clock stays at most 50 kHz
// R04: Output mode drives internal pacer onto pin
// R05: Sync pin powers up as output
// R06: Continuous mode drops first external pulse
// R07: Gated mode uses every external pulse
// R08: Gated source holds pulses off for setup
// R09: Clock mode ignored for internal pacing
// R10: 32-bit counter counts rising input edges
// R11: Counter handles inputs up to 1 MHz
// R12: Queue of channel and range held locally
// R13: Queue holds up to sixteen entries
// R14: Scan starts at entry zero, one sample each
// R15: Wrap to entry zero after last entry
// R16: Stop after host total sample count
// R17: Offset binary, zero volts is code 2048
// R18: Over range saturates at full scale
// R19: Single-ended codes limited to 0..2047
// R20: External pacing starts on sync rising edge
// R21: Scan start resets queue index to zero
// R22: Event counter wraps silently to zero
module dspq_top
  import dspq_pkg::*;
(
  input wire logic clk_i,                          // 100 MHz clock
  input wire logic rst_n_i,                        // Async reset, active low
  input wire logic [AW-1:0] addr_i,                // Register address
  input wire logic [31:0] wdata_i,                 // Write data
  input wire logic wr_i,                           // Write strobe
  input wire logic rd_i,                           // Read strobe
  output logic [31:0] rdata_o,                     // Read data, cycle after rd_i
  input wire logic external_trigger_input,         // Trigger pin
  input wire logic event_counter_input,            // Counter pin
  input wire logic sync_in_i,                      // Sync pin level
  output logic sync_out_o,                         // Sync pin drive value
  output logic sync_oe_o,                          // Sync pin drive enable
  output logic conv_req_o,                         // Conversion start pulse
  output logic [CHW-1:0] conv_chan_o,              // Channel for conversion
  output logic [RGW-1:0] conv_range_o,             // Range for conversion
  input wire logic conv_done_i,                    // Converter result valid
  input wire logic signed [12:0] conv_raw_i,       // Signed reading, LSB units
  input wire logic conv_ovr_i,                     // Converter saw over range
  output logic busy_o                              // Scan in progress
);

  // ==========================================================
  // Registers
  logic [8:0] ctrl_ff;                             // Control bits
  logic [QIW:0] qlen_ff;                           // Queue length 1..16
  logic [31:0] total_ff;                           // Samples to collect
  logic [31:0] pdiv_ff;                            // Internal pacer divider
  logic [31:0] evcnt_ff;                           // Event counter
  logic [CW-1:0] result_ff;                        // Last code
  logic [31:0] count_ff;                           // Samples taken
  dspq_entry_type queue_mem [QDEPTH];              // Queue memory
  dspq_state_type state_ff;                        // Scan state
  logic [QIW-1:0] qidx_ff;                         // Current entry
  logic [31:0] pcnt_ff;                            // Pacer counter
  logic pclk_ff;                                   // Internal pacer square wave
  logic pace_tick;                                 // One pacing event
  logic first_ff;                                  // Next external pulse is first

  // Three-stage synchronisers; stage 0 is read only by stage 1
  logic [2:0] trg_sy_ff, ctr_sy_ff, syn_sy_ff;
  logic trg_lv_ff, ctr_lv_ff, syn_lv_ff;           // Agreed levels

  // Decodes a write to one register
  function automatic logic hit(input logic [AW-1:0] a);
    return wr_i && (addr_i == a);
  endfunction

  // ==========================================================
  // Input synchronisers: a change counts once stages 1 and 2 agree
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      trg_sy_ff <= 3'h0;
      ctr_sy_ff <= 3'h0;
      syn_sy_ff <= 3'h0;
      trg_lv_ff <= 1'b0;
      ctr_lv_ff <= 1'b0;
      syn_lv_ff <= 1'b0;
    end
    else
    begin
      trg_sy_ff <= {trg_sy_ff[1:0], external_trigger_input};
      ctr_sy_ff <= {ctr_sy_ff[1:0], event_counter_input};
      syn_sy_ff <= {syn_sy_ff[1:0], sync_in_i};
      if (trg_sy_ff[1] == trg_sy_ff[2]) trg_lv_ff <= trg_sy_ff[2];
      if (ctr_sy_ff[1] == ctr_sy_ff[2]) ctr_lv_ff <= ctr_sy_ff[2];
      if (syn_sy_ff[1] == syn_sy_ff[2]) syn_lv_ff <= syn_sy_ff[2];
    end
  end

  // Edge events from the agreed levels
  logic trg_edge, ctr_rise, syn_rise;
  logic trg_nxt, ctr_nxt, syn_nxt;
  assign trg_nxt = (trg_sy_ff[1] == trg_sy_ff[2]) ? trg_sy_ff[2] : trg_lv_ff;
  assign ctr_nxt = (ctr_sy_ff[1] == ctr_sy_ff[2]) ? ctr_sy_ff[2] : ctr_lv_ff;
  assign syn_nxt = (syn_sy_ff[1] == syn_sy_ff[2]) ? syn_sy_ff[2] : syn_lv_ff;
  // Polarity choice applies here
  assign trg_edge = ctrl_ff[CTRL_TRIG_FALL] ? (trg_lv_ff & ~trg_nxt)
                                            : (~trg_lv_ff & trg_nxt); // [R01]
  assign ctr_rise = ~ctr_lv_ff & ctr_nxt;          // [R10] [R11]
  assign syn_rise = ~syn_lv_ff & syn_nxt;          // [R20]

  // ==========================================================
  // Control register; start and clear bits are one-cycle commands
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ctrl_ff <= 9'h000;                           // Sync pin output after reset [R05]
    else if (hit(ADDR_CTRL))
      ctrl_ff <= wdata_i[8:0];                     // Direction changes only by command [R02]
    else
    begin
      ctrl_ff[CTRL_START] <= 1'b0;
      ctrl_ff[CTRL_STOP] <= 1'b0;
      ctrl_ff[CTRL_CNT_CLR] <= 1'b0;
    end
  end

  // Scan setup registers
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      qlen_ff <= 5'h01;
      total_ff <= 32'h00000000;
      pdiv_ff <= PACER_DIV_RST;
    end
    else
    begin
      // Lengths beyond sixteen clamp so the index never leaves the memory
      if (hit(ADDR_QLEN))
        qlen_ff <= (wdata_i[7:0] > 8'h10) ? 5'h10 :
                   (wdata_i[7:0] == 8'h00) ? 5'h01 : wdata_i[4:0]; // [R13]
      if (hit(ADDR_TOTAL)) total_ff <= wdata_i;
      if (hit(ADDR_PACER)) pdiv_ff <= wdata_i;
    end
  end

  // Queue memory: one word per entry, no reset needed
  always_ff @(posedge clk_i)
  begin
    if (wr_i && addr_i >= ADDR_QBASE && addr_i < ADDR_QMASK)
      queue_mem[addr_i[QIW+1:2]] <= wdata_i[CHW+RGW-1:0]; // [R12] [R13]
  end

  // ==========================================================
  // Internal pacer: divider runs while a scan is armed or running and is held cleared when idle, square wave for the sync pin
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pcnt_ff <= 32'h00000000;
      pclk_ff <= 1'b0;
    end
    else if (state_ff == ST_IDLE)
    begin
      pcnt_ff <= 32'h00000000;
      pclk_ff <= 1'b0;
    end
    else if (pcnt_ff >= pdiv_ff)
    begin
      pcnt_ff <= 32'h00000000;
      pclk_ff <= ~pclk_ff;
    end
    else
      pcnt_ff <= pcnt_ff + 32'h00000001;
  end

  // Internal ticks on the pacer's rising transition
  logic int_tick;
  assign int_tick = (pcnt_ff >= pdiv_ff) && !pclk_ff;

  // Mode choice matters only for external pacing; internal ticks pass as is
  always_comb
  begin
    if (!ctrl_ff[CTRL_EXTPACE])
      pace_tick = int_tick;                        // [R09]
    else
      pace_tick = syn_rise && (ctrl_ff[CTRL_GATED] || !first_ff); // [R06] [R07] [R08]
  end

  // First-pulse tracker, reloaded at each scan start
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      first_ff <= 1'b1;
    else if (ctrl_ff[CTRL_START])
      first_ff <= 1'b1;
    else if (state_ff == ST_RUN && syn_rise)
      first_ff <= 1'b0;                            // Continuous mode drops this one [R06]
  end

  // ==========================================================
  // Scan sequencer
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_ff <= ST_IDLE;
      qidx_ff <= '0;
      count_ff <= 32'h00000000;
      conv_req_o <= 1'b0;
      conv_chan_o <= '0;
      conv_range_o <= '0;
    end
    else
    begin
      conv_req_o <= 1'b0;
      case (state_ff)
        ST_IDLE:
        begin
          if (ctrl_ff[CTRL_START] && total_ff != 32'h00000000)
          begin
            qidx_ff <= '0;                         // [R21] [R14]
            count_ff <= 32'h00000000;
            state_ff <= ctrl_ff[CTRL_TRIG_EN] ? ST_ARM : ST_RUN;
          end
        end
        ST_ARM:
        begin
          if (ctrl_ff[CTRL_STOP]) state_ff <= ST_IDLE;
          else if (trg_edge) state_ff <= ST_RUN;   // [R01]
        end
        ST_RUN:
        begin
          if (ctrl_ff[CTRL_STOP])
            state_ff <= ST_IDLE;
          else if (pace_tick)
          begin
            // Apply current entry and take one sample
            conv_req_o <= 1'b1;                    // [R14] [R20]
            conv_chan_o <= queue_mem[qidx_ff].chan;
            conv_range_o <= queue_mem[qidx_ff].range;
            qidx_ff <= (5'(qidx_ff) + 5'h01 >= qlen_ff) ? '0 : qidx_ff + 4'h1; // [R15]
            count_ff <= count_ff + 32'h00000001;
            if (count_ff + 32'h00000001 >= total_ff)
              state_ff <= ST_IDLE;                 // [R16]
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Result coding: offset binary with saturation
  logic signed [13:0] biased;
  assign biased = 14'(conv_raw_i) + 14'(CODE_MID); // Zero maps to mid-scale [R17]

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      result_ff <= CODE_MID;
    else if (conv_done_i)
    begin
      if (ctrl_ff[CTRL_SE])
        // Single-ended returns eleven bits only; limits compare signed so negatives clamp low
        result_ff <= (biased > $signed(14'(CODE_SE_FULL))) || (conv_ovr_i && conv_raw_i >= 0) ? CODE_SE_FULL :
                     (biased < 0 || conv_ovr_i) ? 12'h000 : biased[CW-1:0]; // [R19] [R18]
      else
        result_ff <= (biased > $signed(14'(CODE_FULL))) || (conv_ovr_i && conv_raw_i >= 0) ? CODE_FULL :
                     (biased < 0 || conv_ovr_i) ? 12'h000 : biased[CW-1:0]; // [R18]
    end
  end

  // ==========================================================
  // Event counter; rollover is silent
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      evcnt_ff <= 32'h00000000;
    else if (ctr_rise)
      evcnt_ff <= evcnt_ff + 32'h00000001;         // Edge wins over clear [R10] [R22]
    else if (ctrl_ff[CTRL_CNT_CLR])
      evcnt_ff <= 32'h00000000;
  end

  // ==========================================================
  // Sync pin drive: internal pacer out unless external pacing is selected; drive enabled unless configured as input
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync_oe_o <= 1'b1;                           // [R05]
      sync_out_o <= 1'b0;
      busy_o <= 1'b0;
    end
    else
    begin
      sync_oe_o <= ~ctrl_ff[CTRL_SYNC_IN];         // [R02]
      sync_out_o <= pclk_ff & ~ctrl_ff[CTRL_EXTPACE]; // [R04]
      busy_o <= (state_ff != ST_IDLE);
    end
  end

  // ==========================================================
  // Read port: data stands one cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= 32'h00000000;
    else if (rd_i)
    begin
      if (addr_i >= ADDR_QBASE && addr_i < ADDR_QMASK)
        rdata_o <= {26'h0, queue_mem[addr_i[QIW+1:2]]};
      else
        case (addr_i)
          ADDR_CTRL: rdata_o <= {23'h0, ctrl_ff};
          ADDR_STATUS: rdata_o <= {23'h0, syn_lv_ff, trg_lv_ff, first_ff, qidx_ff, state_ff == ST_ARM,
                                   state_ff != ST_IDLE};
          ADDR_QLEN: rdata_o <= {27'h0, qlen_ff};
          ADDR_TOTAL: rdata_o <= total_ff;
          ADDR_PACER: rdata_o <= pdiv_ff;
          ADDR_EVCNT: rdata_o <= evcnt_ff;
          ADDR_RESULT: rdata_o <= {20'h0, result_ff};
          ADDR_COUNT: rdata_o <= count_ff;
          default: rdata_o <= 32'h00000000;
        endcase
    end
    else
      rdata_o <= 32'h00000000;
  end

endmodule // dspq_top

// [tb/dspq_far_model.sv]
// Far side: converter front end plus an external pacing clock source.
// Assumes the bench sets the reading and starts a pulse burst.
module dspq_far_model
  import dspq_pkg::*;
#(
  parameter int N_PULSE = 3                  // Pulses per burst
)
(
  input wire logic clk_i,                    // Clock
  input wire logic rst_n_i,                  // Reset, active low
  input wire logic conv_req_i,               // Conversion start
  input wire logic signed [12:0] raw_i,      // Reading to return
  input wire logic ovr_i,                    // Over range to return
  input wire logic go_i,                     // Start a pulse burst
  output logic conv_done_o,                  // Result valid
  output logic signed [12:0] conv_raw_o,     // Reading
  output logic conv_ovr_o,                   // Over range
  output logic ext_o                         // Pacing clock level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pend_ff; // Request seen last cycle
  int k;         // Burst pulse index

  // ==========================================================
  // Converter answers two cycles after a request; data is garbled otherwise
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pend_ff <= 1'b0;
      conv_done_o <= 1'b0;
      conv_raw_o <= 13'h0000;
      conv_ovr_o <= 1'b0;
    end
    else
    begin
      pend_ff <= conv_req_i;
      conv_done_o <= pend_ff;
      conv_raw_o <= pend_ff ? raw_i : ~conv_raw_o;
      conv_ovr_o <= pend_ff ? ovr_i : ~conv_ovr_o;
    end
  end

  // ==========================================================
  // Burst at the fastest legal rate, held low between bursts for setup
  initial
  begin
    ext_o = 1'b0;
    forever
    begin
      @(posedge clk_i);
      if (go_i)
      begin
        for (k = 0; k < N_PULSE; k++)
        begin
          ext_o <= 1'b1;
          repeat (EXT_MIN_CYC / 2) @(posedge clk_i);
          ext_o <= 1'b0;
          repeat (EXT_MIN_CYC / 2) @(posedge clk_i);
        end
      end
    end
  end
endmodule // dspq_far_model

// [tb/dspq_props.sv]
// Port checker for the scan sequencer, attached by bind.
// Assumes the package constants and the single clk_i domain.
module dspq_props
  import dspq_pkg::*;
(
  input wire logic clk_i,                   // Clock
  input wire logic rst_n_i,                 // Reset, active low
  input wire logic [AW-1:0] addr_i,         // Register address
  input wire logic [31:0] wdata_i,          // Write data
  input wire logic wr_i,                    // Write strobe
  input wire logic rd_i,                    // Read strobe
  input wire logic [31:0] rdata_o,          // Read data
  input wire logic external_trigger_input,  // Trigger pin
  input wire logic event_counter_input,     // Counter pin
  input wire logic sync_in_i,               // Sync pin level
  input wire logic sync_out_o,              // Sync drive value
  input wire logic sync_oe_o,               // Sync drive enable
  input wire logic conv_req_o,              // Conversion start
  input wire logic [CHW-1:0] conv_chan_o,   // Channel
  input wire logic [RGW-1:0] conv_range_o,  // Range
  input wire logic conv_done_i,             // Result valid
  input wire logic signed [12:0] conv_raw_i, // Reading
  input wire logic conv_ovr_i,              // Over range
  input wire logic busy_o                   // Scan active
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // ==========================================================
  // Shadow of the pacing source choice
  logic ext_ff; // External pacing selected
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ext_ff <= 1'b0;
    else if (wr_i && addr_i == ADDR_CTRL)
      ext_ff <= wdata_i[CTRL_EXTPACE];
  end

  // ==========================================================
  // Properties
  chk_oe_keep: assert property ($changed(sync_oe_o) |-> $past(wr_i && addr_i == ADDR_CTRL, 2))
    else $error("sync drive moved without a control write");
  chk_oe_follow: assert property (wr_i && addr_i == ADDR_CTRL |-> ##2 sync_oe_o == !$past(wdata_i[CTRL_SYNC_IN], 2))
    else $error("sync direction does not follow control");
  chk_req_pulse: assert property (conv_req_o |=> !conv_req_o)
    else $error("conversion request longer than one cycle");
  chk_req_busy: assert property (conv_req_o |-> busy_o)
    else $error("conversion request while idle");
  chk_idle_noreq: assert property (!busy_o && !$past(busy_o) |-> !conv_req_o)
    else $error("conversion request outside a scan");
  chk_entry_hold: assert property ($changed({conv_chan_o, conv_range_o}) |-> conv_req_o)
    else $error("entry outputs changed without a request");
  chk_idle_nout: assert property (!busy_o && !$past(busy_o) |-> !sync_out_o)
    else $error("pacer output toggles while idle");
  chk_ext_nout: assert property (ext_ff && $past(ext_ff) |-> !sync_out_o)
    else $error("pacer output runs under external pacing");
  chk_read_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h00000000)
    else $error("read data outside its cycle");
endmodule // dspq_props

bind dspq_top dspq_props u_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .external_trigger_input(external_trigger_input),
  .event_counter_input(event_counter_input), .sync_in_i(sync_in_i), .sync_out_o(sync_out_o),
  .sync_oe_o(sync_oe_o), .conv_req_o(conv_req_o), .conv_chan_o(conv_chan_o), .conv_range_o(conv_range_o),
  .conv_done_i(conv_done_i), .conv_raw_i(conv_raw_i), .conv_ovr_i(conv_ovr_i), .busy_o(busy_o));

// [tb/dspq_top_bench.sv]
// Bench for the scan sequencer: register tasks and directed scans.
// Assumes the far model answers conversions and makes pacing bursts.
`define CHK(nm, e, g) \
  begin \
    n_tests++; \
    if ((g) !== (e)) \
    begin \
      failures++; \
      $display("BAD %s exp %0h got %0h", nm, e, g); \
    end \
  end
module dspq_top_bench;
  import dspq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0; // Clock
  logic rst_n_i = 1'b0; // Reset
  logic [AW-1:0] addr = 8'h00; // Bus address
  logic [31:0] wdata = 32'h00000000; // Bus data
  logic wr_s = 1'b0; // Write strobe
  logic rd_s = 1'b0; // Read strobe
  logic [31:0] rdata; // Read data
  logic trig = 1'b0; // Trigger pin
  logic evc = 1'b0; // Counter pin
  logic go = 1'b0; // Burst start
  logic signed [12:0] raw_v = 13'h0000; // Reading to return
  logic ovr_v = 1'b0; // Over range to return
  logic sync_out, sync_oe, req, done, ovr, busy, ext, so_q; // Port nets
  logic [CHW-1:0] chan; // Channel
  logic [RGW-1:0] range; // Range
  logic signed [12:0] raw; // Reading
  logic [5:0] mon[$]; // Requested entries
  logic [5:0] ent[3] = '{{3'h0, range_bipolar_ten_volt}, {3'h0, range_bipolar_five_volt}, {3'h7, range_bipolar_ten_volt}};
  logic [12:0] rr[4] = '{13'h0000, 13'h0BB8, 13'h1448, 13'h0064}; // Readings
  logic [11:0] rx[4] = '{12'h800, 12'hFFF, 12'h000, 12'h7FF}; // Expected codes
  int failures = 0;
  int n_tests = 0;
  int rises = 0;
  int cyc = 0;

  dspq_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s),
    .rdata_o(rdata), .external_trigger_input(trig), .event_counter_input(evc),
    .sync_in_i(sync_oe ? sync_out : ext), .sync_out_o(sync_out), .sync_oe_o(sync_oe), .conv_req_o(req),
    .conv_chan_o(chan), .conv_range_o(range), .conv_done_i(done), .conv_raw_i(raw), .conv_ovr_i(ovr),
    .busy_o(busy));
  dspq_far_model far (.clk_i(clk_i), .rst_n_i(rst_n_i), .conv_req_i(req), .raw_i(raw_v), .ovr_i(ovr_v),
    .go_i(go), .conv_done_o(done), .conv_raw_o(raw), .conv_ovr_o(ovr), .ext_o(ext));

  // ==========================================================
  // Clock, monitor and hang guard
  initial
  begin
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    if (req === 1'b1)
      mon.push_back({chan, range});
    if (sync_out === 1'b1 && so_q === 1'b0)
      rises++;
    so_q <= sync_out;
    cyc++;
    if (cyc == 30000)
    begin
      failures++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // Bus tasks
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_i);
    wr_s <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [AW-1:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_i);
    rd_s <= 1'b0;
    @(posedge clk_i);
    `CHK(nm, e, rdata)
  endtask
  task automatic wait_idle;
    repeat (3) @(posedge clk_i); // A start needs two edges to show on busy
    for (int i = 0; i < 3000 && busy !== 1'b0; i++)
      @(posedge clk_i);
    `CHK("busy", 1'b0, busy)
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    `CHK("oe_rst", 1'b1, sync_oe)
    rchk("pacer_rst", ADDR_PACER, PACER_DIV_RST);
    rchk("unmapped", 8'h3C, 32'h00000000);
    wr(ADDR_QLEN, 32'h00000011);
    rchk("qlen_max", ADDR_QLEN, 32'h00000010);
    for (int i = 0; i < 3; i++)
      wr(ADDR_QBASE + 8'(4 * i), {26'h0, ent[i]});
    wr(ADDR_QLEN, 32'h00000003);
    wr(ADDR_TOTAL, 32'h00000007);
    wr(ADDR_PACER, 32'h00000004);
    // Internal scan with the gated bit set must still pace normally
    wr(ADDR_CTRL, 32'h00000009);
    wait_idle();
    `CHK("nreq", 32'h7, 32'(mon.size()))
    for (int i = 0; i < 7; i++)
      `CHK("entry", ent[i % 3], mon[i])
    `CHK("pacer_out", 1'b1, rises != 0)
    rchk("count", ADDR_COUNT, 32'h00000007);
    // The last scan stopped mid-list; a new scan restarts at entry zero
    mon.delete();
    wr(ADDR_TOTAL, 32'h00000002);
    wr(ADDR_CTRL, 32'h00000001);
    wait_idle();
    `CHK("restart", {ent[0], ent[1]}, {mon[0], mon[1]})
    wr(ADDR_TOTAL, 32'h00000001);
    for (int i = 0; i < 4; i++)
    begin
      raw_v <= rr[i];
      ovr_v <= (i == 1 || i == 2);
      wr(ADDR_CTRL, (i == 3) ? 32'h00000081 : 32'h00000001);
      wait_idle();
      rchk("result", ADDR_RESULT, {20'h0, rx[i]});
    end
    // Trigger edge choice: nothing before the edge, one sample after
    for (int p = 0; p < 2; p++)
    begin
      trig <= p[0];
      repeat (8) @(posedge clk_i);
      mon.delete();
      wr(ADDR_CTRL, 32'h00000041 | (32'(p) << CTRL_TRIG_FALL));
      repeat (40) @(posedge clk_i);
      `CHK("pre_trig", 32'h0, 32'(mon.size()))
      trig <= ~p[0];
      wait_idle();
      `CHK("post_trig", 32'h1, 32'(mon.size()))
    end
    trig <= 1'b0;
    // External pacing: continuous drops the first pulse, gated uses all
    wr(ADDR_TOTAL, 32'h00000004);
    for (int g = 0; g < 2; g++)
    begin
      wr(ADDR_CTRL, 32'h00000015 | (32'(g) << CTRL_GATED));
      repeat (20) @(posedge clk_i);
      `CHK("oe_in", 1'b0, sync_oe)
      mon.delete();
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      repeat (3 * EXT_MIN_CYC + 100) @(posedge clk_i);
      `CHK("ext_reqs", (g ? 32'h3 : 32'h2), 32'(mon.size()))
      wr(ADDR_CTRL, 32'h00000002);
      wait_idle();
    end
    // Event counter at the fastest rated input rate
    wr(ADDR_CTRL, 32'h00000100);
    repeat (5)
    begin
      evc <= 1'b1;
      repeat (50) @(posedge clk_i);
      evc <= 1'b0;
      repeat (50) @(posedge clk_i);
    end
    rchk("evcnt", ADDR_EVCNT, 32'h00000005);
    wr(ADDR_CTRL, 32'h00000100);
    rchk("evclr", ADDR_EVCNT, 32'h00000000);
    tally_and_finish();
  end
endmodule // dspq_top_bench
